// file: hw/ucs_params.svh
`ifndef UCS_PARAMS_SVH
`define UCS_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UCS_CSR_OFF 8'hf8
`define UCS_DATA_OFF 8'h00
`define UCS_FRAME_OFF 8'h04
`define UCS_IST_OFF 8'h08
`define UCS_IMSK_OFF 8'h0c

// ----------------------------------------
// Control/status fields and reset
// ----------------------------------------
`define UCS_MODE_BIT 7
`define UCS_RXON_BIT 6
`define UCS_SLAVE_BIT 5
`define UCS_FE_BIT 4
`define UCS_PE_BIT 3
`define UCS_RXB_BIT 2
`define UCS_TXB_BIT 1
`define UCS_ACT_BIT 0
`define UCS_CSR_RST 7'h00

// ----------------------------------------
// Frame format fields and reset
// ----------------------------------------
`define UCS_START_BIT 0
`define UCS_STOP_BIT 1
`define UCS_SPB_BIT 2
`define UCS_PAREN_BIT 3
`define UCS_ODD_BIT 5
`define UCS_FRAME_MASK 8'h2f
`define UCS_FRAME_RST 8'h02

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define UCS_IRQ_RX 0
`define UCS_IRQ_TX 1
`define UCS_IRQ_FE 2
`define UCS_IRQ_PE 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define UCS_CLK_HZ 50000000
`define UCS_BAUD 115200
`define UCS_BIT_CYC (`UCS_CLK_HZ / `UCS_BAUD)

`endif

// file: hw/ucs_pkg.sv
package ucs_pkg;

`include "ucs_params.svh"

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [15:0] ucs_cnt_t;

    typedef struct packed {
        logic start_lvl;
        logic stop_lvl;
        logic two_stop;
        logic par_en;
        logic par_odd;
    } ucs_frame_s;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2} ucs_rx_e;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucs_tx_e;
    typedef enum logic [2:0] {REG_NONE, REG_CSR, REG_DATA, REG_FRAME, REG_IST, REG_IMSK} ucs_reg_e;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ucs_sync_s;

    typedef struct packed {
        ucs_tx_e st;
        ucs_cnt_t cnt;
        logic [7:0] sh;
        logic [2:0] nbit;
        logic par;
        logic nstop;
        logic line;
        logic done;
    } ucs_tx_s;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Parity bit for a byte, even or odd
    function automatic logic ucs_parity(input logic [7:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction

    // Frame format from its register image
    function automatic ucs_frame_s ucs_frame_of(input logic [7:0] r);
        return '{r[`UCS_START_BIT], r[`UCS_STOP_BIT], r[`UCS_SPB_BIT],
                 r[`UCS_PAREN_BIT], r[`UCS_ODD_BIT]};
    endfunction

    // Register select from an APB byte address
    function automatic ucs_reg_e ucs_decode(input logic [7:0] a);
        ucs_reg_e r;
        r = REG_NONE;
        if (a == `UCS_CSR_OFF) r = REG_CSR;
        if (a == `UCS_DATA_OFF) r = REG_DATA;
        if (a == `UCS_FRAME_OFF) r = REG_FRAME;
        if (a == `UCS_IST_OFF) r = REG_IST;
        if (a == `UCS_IMSK_OFF) r = REG_IMSK;
        return r;
    endfunction

endpackage

// file: hw/ucs_tx_if.sv
`timescale 1ns/1ps

interface ucs_tx_if;
    logic go;
    logic [7:0] data;
    ucs_pkg::ucs_frame_s cfg;
    logic busy;
    logic done;
    logic line;

    modport ctl (output go, data, cfg, input busy, done, line);
    modport eng (input go, data, cfg, output busy, done, line);
endinterface

// file: hw/ucs_pin_sync.sv
`timescale 1ns/1ps

module ucs_pin_sync #(
    parameter bit RST_LVL = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    ucs_pkg::ucs_sync_s q;
    ucs_pkg::ucs_sync_s n;

    // Three stages; a change counts once stages two and three agree
    always_comb
    begin
        n = q;
        n.s1 = pin;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) n.lvl = q.s3;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) q <= {RST_LVL, RST_LVL, RST_LVL, RST_LVL};
        else q <= n;
    end

    assign level = q.lvl;
endmodule

// file: hw/ucs_tx.sv
`timescale 1ns/1ps
`include "ucs_params.svh"

module ucs_tx #(
    parameter int BIT_CYC = `UCS_BIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    ucs_tx_if.eng tx
);
    ucs_pkg::ucs_tx_s q;
    ucs_pkg::ucs_tx_s n;

    if (BIT_CYC < 4 || BIT_CYC > 65535)
    begin : g_chk
        $error("ucs_tx: BIT_CYC out of range");
    end

    // ----------------------------------------
    // Serialiser: start, data LSB first, parity, stops
    // ----------------------------------------
    always_comb
    begin
        n = q;
        n.done = 1'b0;
        if (q.cnt != 16'h0000) n.cnt = q.cnt - 16'h0001;
        unique case (q.st)
            ucs_pkg::TX_IDLE:
            begin
                n.line = ~tx.cfg.start_lvl;
                if (tx.go)
                begin
                    n.st = ucs_pkg::TX_START;
                    n.sh = tx.data;
                    n.par = ucs_pkg::ucs_parity(tx.data, tx.cfg.par_odd);
                    n.cnt = 16'(BIT_CYC - 1);
                    n.line = tx.cfg.start_lvl;
                end
            end
            ucs_pkg::TX_START:
                if (q.cnt == 16'h0000)
                begin
                    n.st = ucs_pkg::TX_DATA;
                    n.nbit = 3'h0;
                    n.line = q.sh[0];
                    n.cnt = 16'(BIT_CYC - 1);
                end
            ucs_pkg::TX_DATA:
                if (q.cnt == 16'h0000)
                begin
                    n.cnt = 16'(BIT_CYC - 1);
                    n.sh = {1'b0, q.sh[7:1]};
                    n.line = q.sh[1];
                    n.nbit = q.nbit + 3'h1;
                    if (q.nbit == 3'h7)
                    begin
                        n.st = tx.cfg.par_en ? ucs_pkg::TX_PAR : ucs_pkg::TX_STOP;
                        n.line = tx.cfg.par_en ? q.par : tx.cfg.stop_lvl;
                        n.nstop = tx.cfg.two_stop;
                    end
                end
            ucs_pkg::TX_PAR:
                if (q.cnt == 16'h0000)
                begin
                    n.cnt = 16'(BIT_CYC - 1);
                    n.st = ucs_pkg::TX_STOP;
                    n.line = tx.cfg.stop_lvl;
                end
            ucs_pkg::TX_STOP:
                if (q.cnt == 16'h0000)
                begin
                    n.cnt = 16'(BIT_CYC - 1);
                    n.nstop = 1'b0;
                    if (!q.nstop)
                    begin
                        n.st = ucs_pkg::TX_IDLE;
                        n.done = 1'b1;
                        n.line = ~tx.cfg.start_lvl;
                    end
                end
            default: n.st = ucs_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.line <= 1'b1;
        end
        else q <= n;
    end

    assign tx.busy = q.st != ucs_pkg::TX_IDLE;
    assign tx.done = q.done;
    assign tx.line = q.line;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_tx_done;
        q.done |-> (q.st == ucs_pkg::TX_IDLE) && $past(q.st == ucs_pkg::TX_STOP);
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("done without stop bit");

    property p_tx_go;
        (tx.go && q.st == ucs_pkg::TX_IDLE) |=> tx.busy && (q.line == $past(tx.cfg.start_lvl));
    endproperty
    a_tx_go: assert property (p_tx_go) else $error("start bit not driven");
endmodule

// file: hw/ucs_top.sv
`timescale 1ns/1ps
`include "ucs_params.svh"

// Notes on behaviour
// - Bit 7 picks UART when 1, SPI when 0; bit 5 picks SPI slave.
// - Bit 6 enables reception only in UART mode (bit 7 set); while 0 no byte is taken in.
// - Bit 4 sets when a received stop bit has the wrong level.
// - Byte flags rise on good first stop; bad second stop flags one bit later.
// - Bit 3 sets when a received byte fails its parity check.
// - Bit 2 sets when a received byte is ready for reading.
// - Bit 1 sets once the last written byte has been fully sent.
// - Bit 0 is read-only, high while transmitting or receiving.
// - Parity is checked only while parity checking is enabled.
module ucs_top #(
    parameter int BIT_CYC = `UCS_BIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    output logic spi_mode,
    output logic spi_slave,
    output logic irq
);
    if (BIT_CYC < 4 || BIT_CYC > 65535)
    begin : g_chk
        $error("ucs_top: BIT_CYC out of range");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:1] csr;
        logic [7:0] frame;
        logic [3:0] ist;
        logic [3:0] imsk;
        logic [7:0] rxbuf;
        logic [31:0] rdata;
        logic slverr;
        logic tx_go;
        logic [7:0] tx_data;
        ucs_pkg::ucs_rx_e rx_st;
        ucs_pkg::ucs_cnt_t rx_cnt;
        logic [7:0] rx_sh;
        logic [2:0] rx_nbit;
        logic rx_pbad;
        ucs_pkg::ucs_cnt_t since;
    } ucs_top_s;

    ucs_top_s q;
    ucs_top_s n;
    ucs_pkg::ucs_frame_s fc;
    ucs_pkg::ucs_reg_e sel;
    logic line;
    logic rx_en;
    logic rx_busy;
    logic busy;
    logic tick;
    logic setup;
    logic access;
    logic ev_byte;
    logic ev_fe;
    logic ev_pe;
    logic [7:0] rd;

    ucs_tx_if txi();

    // ----------------------------------------
    // Receive pin and transmitter
    // ----------------------------------------
    ucs_pin_sync #(
        .RST_LVL(1'b1)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(rxd),
        .level(line)
    );

    ucs_tx #(
        .BIT_CYC(BIT_CYC)
    ) u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .tx(txi.eng)
    );

    // Transmitter request and format from registers
    assign txi.go = q.tx_go;
    assign txi.data = q.tx_data;
    assign txi.cfg = fc;

    // Decoded controls
    assign fc = ucs_pkg::ucs_frame_of(q.frame);
    assign rx_en = q.csr[`UCS_RXON_BIT] & q.csr[`UCS_MODE_BIT];
    assign rx_busy = q.rx_st != ucs_pkg::RX_IDLE;
    assign busy = rx_busy | txi.busy;
    assign tick = q.rx_cnt == 16'h0000;
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign sel = ucs_pkg::ucs_decode(paddr);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        n = q;
        ev_byte = 1'b0;
        ev_fe = 1'b0;
        ev_pe = 1'b0;
        rd = 8'h00;
        n.tx_go = 1'b0;
        if (q.since != 16'hffff) n.since = q.since + 16'h0001;
        if (q.rx_cnt != 16'h0000) n.rx_cnt = q.rx_cnt - 16'h0001;

        // Receiver, sampling each bit at its middle
        if (!rx_en) n.rx_st = ucs_pkg::RX_IDLE;
        else unique case (q.rx_st)
            ucs_pkg::RX_IDLE:
                if (line == fc.start_lvl)
                begin
                    n.rx_st = ucs_pkg::RX_START;
                    n.rx_cnt = 16'(BIT_CYC / 2 - 1);
                end
            ucs_pkg::RX_START:
                if (tick)
                begin
                    n.rx_cnt = 16'(BIT_CYC - 1);
                    n.rx_nbit = 3'h0;
                    n.rx_pbad = 1'b0;
                    n.rx_st = (line == fc.start_lvl) ? ucs_pkg::RX_DATA : ucs_pkg::RX_IDLE;
                end
            ucs_pkg::RX_DATA:
                if (tick)
                begin
                    n.rx_cnt = 16'(BIT_CYC - 1);
                    n.rx_sh = {line, q.rx_sh[7:1]};
                    n.rx_nbit = q.rx_nbit + 3'h1;
                    if (q.rx_nbit == 3'h7)
                        n.rx_st = fc.par_en ? ucs_pkg::RX_PAR : ucs_pkg::RX_STOP1;
                end
            ucs_pkg::RX_PAR:
                if (tick)
                begin
                    n.rx_cnt = 16'(BIT_CYC - 1);
                    n.rx_pbad = line != ucs_pkg::ucs_parity(q.rx_sh, fc.par_odd);
                    n.rx_st = ucs_pkg::RX_STOP1;
                end
            ucs_pkg::RX_STOP1:
                if (tick)
                begin
                    n.rx_cnt = 16'(BIT_CYC - 1);
                    n.rx_st = ucs_pkg::RX_IDLE;
                    n.rxbuf = q.rx_sh;
                    ev_pe = q.rx_pbad & fc.par_en;
                    if (line == fc.stop_lvl)
                    begin
                        ev_byte = 1'b1;
                        if (fc.two_stop) n.rx_st = ucs_pkg::RX_STOP2;
                    end
                    else ev_fe = 1'b1;
                end
            ucs_pkg::RX_STOP2:
                if (tick)
                begin
                    n.rx_st = ucs_pkg::RX_IDLE;
                    ev_fe = line != fc.stop_lvl;
                end
            default: n.rx_st = ucs_pkg::RX_IDLE;
        endcase
        if (ev_byte) n.since = 16'h0000;

        // Read mux, captured in the setup cycle
        unique case (sel)
            ucs_pkg::REG_CSR: rd = {q.csr, busy};
            ucs_pkg::REG_DATA: rd = q.rxbuf;
            ucs_pkg::REG_FRAME: rd = q.frame;
            ucs_pkg::REG_IST: rd = {4'h0, q.ist};
            ucs_pkg::REG_IMSK: rd = {4'h0, q.imsk};
            ucs_pkg::REG_NONE: rd = 8'h00;
            default: rd = 8'h00;
        endcase
        if (setup)
        begin
            n.rdata = {24'h00_0000, rd};
            n.slverr = sel == ucs_pkg::REG_NONE;
        end

        // Register writes at the access edge
        if (access && pwrite)
        begin
            unique case (sel)
                ucs_pkg::REG_CSR:
                begin
                    n.csr[7:5] = pwdata[7:5];
                    n.csr[`UCS_FE_BIT:`UCS_TXB_BIT] =
                        q.csr[`UCS_FE_BIT:`UCS_TXB_BIT] & pwdata[4:1];
                end
                ucs_pkg::REG_DATA:
                    if (q.csr[`UCS_MODE_BIT] && !txi.busy && !q.tx_go)
                    begin
                        n.tx_go = 1'b1;
                        n.tx_data = pwdata[7:0];
                    end
                ucs_pkg::REG_FRAME: n.frame = pwdata[7:0] & `UCS_FRAME_MASK;
                ucs_pkg::REG_IST: n.ist = q.ist & ~pwdata[3:0];
                ucs_pkg::REG_IMSK: n.imsk = pwdata[3:0];
                ucs_pkg::REG_NONE: n.slverr = q.slverr;
                default: n.slverr = q.slverr;
            endcase
        end

        // Hardware events set flags; setting wins over a clear
        n.csr[`UCS_FE_BIT] = n.csr[`UCS_FE_BIT] | ev_fe;
        n.csr[`UCS_PE_BIT] = n.csr[`UCS_PE_BIT] | ev_pe;
        n.csr[`UCS_RXB_BIT] = n.csr[`UCS_RXB_BIT] | ev_byte;
        n.csr[`UCS_TXB_BIT] = n.csr[`UCS_TXB_BIT] | txi.done;
        n.ist[`UCS_IRQ_RX] = n.ist[`UCS_IRQ_RX] | ev_byte;
        n.ist[`UCS_IRQ_TX] = n.ist[`UCS_IRQ_TX] | txi.done;
        n.ist[`UCS_IRQ_FE] = n.ist[`UCS_IRQ_FE] | ev_fe;
        n.ist[`UCS_IRQ_PE] = n.ist[`UCS_IRQ_PE] | ev_pe;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.csr <= `UCS_CSR_RST;
            q.frame <= `UCS_FRAME_RST;
        end
        else q <= n;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pready = 1'b1;
    assign prdata = q.rdata;
    assign pslverr = q.slverr & access;
    assign txd = txi.line;
    assign spi_mode = ~q.csr[`UCS_MODE_BIT];
    assign spi_slave = ~q.csr[`UCS_MODE_BIT] & q.csr[`UCS_SLAVE_BIT];
    assign irq = |(q.ist & q.imsk);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_csr_wr;
        access && pwrite && (paddr == `UCS_CSR_OFF);
    endsequence

    sequence s_csr_rd;
        setup && !pwrite && (paddr == `UCS_CSR_OFF);
    endsequence

    property p_mode;
        s_csr_wr |=> (spi_mode == !$past(pwdata[7]))
            && (spi_slave == $past(!pwdata[7] && pwdata[5]));
    endproperty
    a_mode: assert property (p_mode) else $error("mode select mismatch");

    property p_rx_off;
        (!q.csr[`UCS_RXON_BIT] && !rx_busy) |=> !rx_busy && !ev_byte;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receiver ran while off");

    property p_fe;
        ev_fe |=> q.csr[`UCS_FE_BIT] && q.ist[`UCS_IRQ_FE];
    endproperty
    a_fe: assert property (p_fe) else $error("framing error not flagged");

    property p_fe_late;
        (ev_fe && q.rx_st == ucs_pkg::RX_STOP2) |-> q.since == 16'(BIT_CYC - 1);
    endproperty
    a_fe_late: assert property (p_fe_late) else $error("late framing error timing");

    property p_pe;
        ev_pe |=> q.csr[`UCS_PE_BIT] && q.ist[`UCS_IRQ_PE];
    endproperty
    a_pe: assert property (p_pe) else $error("parity error not flagged");

    property p_rxb;
        ev_byte |=> q.csr[`UCS_RXB_BIT] && q.ist[`UCS_IRQ_RX] && (q.rx_st != ucs_pkg::RX_STOP1);
    endproperty
    a_rxb: assert property (p_rxb) else $error("byte ready not flagged");

    property p_txb;
        txi.done |=> q.csr[`UCS_TXB_BIT];
    endproperty
    a_txb: assert property (p_txb) else $error("sent byte not flagged");

    property p_act;
        s_csr_rd |=> prdata[`UCS_ACT_BIT] == $past(rx_busy || txi.busy);
    endproperty
    a_act: assert property (p_act) else $error("activity bit wrong");

    property p_par_off;
        !fc.par_en |-> !ev_pe;
    endproperty
    a_par_off: assert property (p_par_off) else $error("parity error while disabled");

    property p_w1_keep;
        (s_csr_wr and (q.csr[`UCS_RXB_BIT] && pwdata[`UCS_RXB_BIT])) |=> q.csr[`UCS_RXB_BIT];
    endproperty
    a_w1_keep: assert property (p_w1_keep) else $error("writing one cleared flag");

    property p_w0_clr;
        (s_csr_wr and (!pwdata[`UCS_RXB_BIT] && !ev_byte)) |=> !q.csr[`UCS_RXB_BIT];
    endproperty
    a_w0_clr: assert property (p_w0_clr) else $error("writing zero kept flag");
endmodule

// file: bench/ucs_peer.sv
`timescale 1ns/1ps

// ----------------------------------------
// Serial peer on the far side of the channel
// ----------------------------------------
module ucs_peer #(
    parameter int BIT_CYC = 16
) (
    input wire logic pclk,
    input wire logic txd,
    output logic rxd
);
    // Line idles high between frames
    initial rxd = 1'b1;

    // One bit period on the line
    task automatic put(input logic v);
        rxd <= v;
        repeat (BIT_CYC) @(posedge pclk);
    endtask

    // Frame towards the device, LSB first
    task automatic send(input logic [7:0] d, input logic pen, input logic pb,
                        input logic two, input logic s1, input logic s2);
        @(posedge pclk);
        put(1'b0);
        for (int i = 0; i < 8; i++)
        begin
            put(d[i]);
        end
        if (pen)
        begin
            put(pb);
        end
        put(s1);
        if (two)
        begin
            put(s2);
        end
        rxd <= 1'b1;
    endtask

    // Frame from the device, sampled mid-bit, stop level in f[8]
    task automatic recv(output logic [8:0] f);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 4000)
        begin
            @(negedge pclk);
            n++;
        end
        repeat (BIT_CYC / 2) @(negedge pclk);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT_CYC) @(negedge pclk);
            f[i] = txd;
        end
    endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
`include "ucs_params.svh"

module tb;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    localparam int BIT_CYC = 16;
    localparam logic [7:0] CSR = `UCS_CSR_OFF;
    localparam logic [7:0] DAT = `UCS_DATA_OFF;
    localparam logic [7:0] FRM = `UCS_FRAME_OFF;
    localparam logic [7:0] IST = `UCS_IST_OFF;
    localparam logic [7:0] MSK = `UCS_IMSK_OFF;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready, pslverr, txd, rxd, spi_mode, spi_slave, irq;
    logic [31:0] prdata;
    logic [8:0] f;
    int num_errors = 0;
    int n_compared = 0;
    int t1, t2;

    ucs_top #(.BIT_CYC(BIT_CYC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .rxd(rxd), .txd(txd),
        .spi_mode(spi_mode), .spi_slave(spi_slave), .irq(irq));
    ucs_peer #(.BIT_CYC(BIT_CYC)) peer (.pclk(pclk), .txd(txd), .rxd(rxd));

    // Clock and watchdog
    always #10 pclk = ~pclk;
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("MISMATCH watchdog expected done seen hang");
        end_of_test();
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask

    // One APB transfer, answer taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, d, r, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
        logic [31:0] r;
        logic er;
        apb(1'b0, a, 8'h00, r, er);
        chk(w, e, r);
    endtask

    task automatic rx_case(input logic [7:0] fm, input logic [7:0] d, input logic pb,
                           input logic s1, input logic s2, input logic [7:0] e);
        wr(CSR, 8'hC0);
        wr(FRM, fm);
        peer.send(d, fm[3], pb, fm[2], s1, s2);
        repeat (BIT_CYC) @(posedge pclk);
        rd(CSR, e, "csr after frame");
    endtask

    task automatic irq_time(input logic [7:0] m, output int t);
        wr(FRM, 8'h06);
        wr(IST, 8'h0F);
        wr(CSR, 8'hC0);
        wr(MSK, m);
        t = 0;
        fork
            peer.send(8'h96, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
            while (irq !== 1'b1 && t < 400)
            begin
                @(negedge pclk);
                t++;
            end
        join
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        logic er;
        chk("reset pins", 32'h0000_0003, {irq, spi_slave, spi_mode, txd});
        rd(CSR, 8'h00, "csr reset");
        rd(FRM, 8'h02, "frame reset");
        apb(1'b0, 8'h40, 8'h00, r, er);
        chk("unmapped err", 1, er);
    endtask

    task automatic t_mode();
        wr(CSR, 8'h20);
        @(negedge pclk);
        chk("spi slave", 3, {spi_mode, spi_slave});
        wr(CSR, 8'hA1);
        @(negedge pclk);
        chk("uart mode", 0, {spi_mode, spi_slave});
        rd(CSR, 8'hA0, "csr mode");
    endtask

    task automatic t_rx();
        wr(CSR, 8'h80);
        peer.send(8'h5A, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        rd(CSR, 8'h80, "csr rx off");
        rx_case(8'h02, 8'hA5, 0, 1, 1, 8'hC4);
        rd(DAT, 8'hA5, "rx data");
        wr(CSR, 8'hC4);
        rd(CSR, 8'hC4, "csr write one");
        rx_case(8'h0A, 8'h07, 0, 1, 1, 8'hCC);
        rx_case(8'h0A, 8'h07, 1, 1, 1, 8'hC4);
        rx_case(8'h2A, 8'h07, 1, 1, 1, 8'hCC);
        rx_case(8'h2A, 8'h07, 0, 1, 1, 8'hC4);
        rx_case(8'h22, 8'h07, 1, 1, 1, 8'hC4);
        rx_case(8'h02, 8'h3C, 0, 0, 1, 8'hD0);
        rx_case(8'h00, 8'h3C, 0, 0, 1, 8'hC4);
        rx_case(8'h06, 8'h3C, 0, 1, 0, 8'hD4);
    endtask

    task automatic t_irq();
        irq_time(8'h01, t1);
        irq_time(8'h04, t2);
        chk("fe delay", BIT_CYC, t2 - t1);
        wr(MSK, 8'h00);
        @(negedge pclk);
        chk("irq masked", 0, irq);
        wr(MSK, 8'h04);
        @(negedge pclk);
        chk("irq unmasked", 1, irq);
        wr(IST, 8'h04);
        @(negedge pclk);
        chk("irq cleared", 0, irq);
    endtask

    task automatic t_tx();
        wr(MSK, 8'h02);
        wr(CSR, 8'h80);
        fork
            peer.recv(f);
            begin
                wr(DAT, 8'h3C);
                repeat (4) @(posedge pclk);
                rd(CSR, 8'h81, "csr while sending");
            end
        join
        chk("tx frame", 9'h13C, f);
        repeat (2 * BIT_CYC) @(posedge pclk);
        rd(CSR, 8'h82, "csr sent");
        chk("irq tx", 1, irq);
        wr(IST, 8'h02);
        @(negedge pclk);
        chk("irq tx cleared", 0, irq);
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mode();
        t_rx();
        t_irq();
        t_tx();
        end_of_test();
    end
endmodule
